// File: common/indirect_addr_pkg.sv
// Shared constants, types and the operand address decoder for indirect addressing
package indirect_addr_pkg;

  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int PTR_COUNT = 3;
  localparam int PTR_IDX_W = 2;

  // Operand block of pointer n sits at plain address minus n strides
  localparam logic [11:0] PTR_ONE_PLAIN_ADDR = 12'hfe7;
  localparam logic [11:0] PTR_BLOCK_STRIDE   = 12'h008;
  localparam logic [11:0] PTR_ZERO_PLAIN_ADDR = PTR_ONE_PLAIN_ADDR + PTR_BLOCK_STRIDE;

  // Distance below the plain operand address of each member of a block
  localparam logic [11:0] OFF_PLAIN   = 12'h000;
  localparam logic [11:0] OFF_POST_INCREMENT_OPERAND = 12'h001;
  localparam logic [11:0] OFF_POST_DECREMENT_OPERAND = 12'h002;
  localparam logic [11:0] OFF_PRE_INCREMENT_OPERAND  = 12'h003;
  localparam logic [11:0] OFF_W_OFFSET_OPERAND   = 12'h004;
  localparam logic [11:0] OFF_HIGH    = 12'h005;
  localparam logic [11:0] OFF_LOW     = 12'h006;

  // Direct addressing, read-back and pointer step constants
  localparam logic [7:0]  LIT_OFFSET_MAX   = 8'h5f;
  localparam logic [3:0]  ACCESS_HIGH_PAGE = 4'hf;
  localparam logic [3:0]  ACCESS_LOW_PAGE  = 4'h0;
  localparam logic [3:0]  HIGH_UNUSED_BITS = 4'h0;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [11:0] PTR_STEP         = 12'h001;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_PLAIN   = 3'b001,
    OP_POST_INCREMENT_OPERAND = 3'b010,
    OP_POST_DECREMENT_OPERAND = 3'b011,
    OP_PRE_INCREMENT_OPERAND  = 3'b100,
    OP_W_OFFSET_OPERAND   = 3'b101,
    OP_HIGH    = 3'b110,
    OP_LOW     = 3'b111
  } op_kind_t;

  typedef enum logic [1:0] {
    STEP_HOLD = 2'b00,
    STEP_INC  = 2'b01,
    STEP_DEC  = 2'b10
  } step_t;

  typedef struct packed {
    logic                 hit;
    logic [PTR_IDX_W-1:0] idx;
    op_kind_t             kind;
  } decode_t;

  // Finds which pointer operand or pointer register an address names
  function automatic decode_t decode_addr(input logic [11:0] addr);
    decode_t     d;
    logic [11:0] diff;
    d = '{hit: 1'b0, idx: '0, kind: OP_NONE};
    for (int n = 0; n < PTR_COUNT; n++)
    begin
      diff = PTR_ZERO_PLAIN_ADDR - 12'(n * PTR_BLOCK_STRIDE) - addr;
      if (diff <= OFF_LOW)
      begin
        d.hit = 1'b1;
        d.idx = PTR_IDX_W'(n);
        if (diff == OFF_PLAIN)
          d.kind = OP_PLAIN;
        else if (diff == OFF_POST_INCREMENT_OPERAND)
          d.kind = OP_POST_INCREMENT_OPERAND;
        else if (diff == OFF_POST_DECREMENT_OPERAND)
          d.kind = OP_POST_DECREMENT_OPERAND;
        else if (diff == OFF_PRE_INCREMENT_OPERAND)
          d.kind = OP_PRE_INCREMENT_OPERAND;
        else if (diff == OFF_W_OFFSET_OPERAND)
          d.kind = OP_W_OFFSET_OPERAND;
        else if (diff == OFF_HIGH)
          d.kind = OP_HIGH;
        else
          d.kind = OP_LOW;
      end
    end
    return d;
  endfunction

endpackage

// File: design/pointer_pair.sv
// One 12-bit pointer pair with byte loads and whole-pair stepping
`timescale 1ns/1ns
module pointer_pair
  import indirect_addr_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             nrst_in,
  // Control
  input  wire logic             wr_high_in,
  input  wire logic             wr_low_in,
  input  wire logic [7:0]       wdata_in,
  input  wire indirect_addr_pkg::step_t step_in,
  // Pointer value
  output logic      [WIDTH-1:0] value_out
);
  import indirect_addr_pkg::*;

  if (WIDTH <= 8 || WIDTH > 16)
    $error("pointer_pair: WIDTH must be 9 to 16");

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } pair_state_t;

  pair_state_t s;
  pair_state_t next_s;

  always_comb
  begin
    next_s = s;
    // A byte load wins over stepping, so a write through an operand lands unmodified
    if (wr_high_in || wr_low_in)
    begin
      if (wr_high_in)
        next_s.value[WIDTH-1:8] = wdata_in[WIDTH-9:0];
      if (wr_low_in)
        next_s.value[7:0] = wdata_in;
    end
    else if (step_in == STEP_INC)
      next_s.value = s.value + WIDTH'(PTR_STEP);
    else if (step_in == STEP_DEC)
      next_s.value = s.value - WIDTH'(PTR_STEP);
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign value_out = s.value;

endmodule

// File: design/indirect_data_address_unit.sv
// Data-memory address generation: direct, banked, indirect and literal-offset modes
`timescale 1ns/1ns
module indirect_data_address_unit
  import indirect_addr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // Configuration
  input  wire logic        extended_instruction_enable_in,
  // Request from the execute stage
  input  wire logic        acc_valid_in,
  input  wire logic        acc_write_in,
  input  wire logic        access_select_in,
  input  wire logic [7:0]  file_addr_in,
  input  wire logic [3:0]  bank_select_register_in,
  input  wire logic [7:0]  w_in,
  input  wire logic [7:0]  wdata_in,
  // Data memory port
  output logic      [11:0] mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic      [7:0]  mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  // Read answer to the core
  output logic      [7:0]  rdata_out,
  output logic             rdata_valid_out,
  // Pointer pairs as seen by the core
  output logic      [11:0] pointer_zero_out,
  output logic      [11:0] pointer_one_out,
  output logic      [11:0] pointer_two_out
);
  import indirect_addr_pkg::*;

  typedef struct packed {
    logic [11:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic        int_rd;
    logic [7:0]  int_data;
    logic [7:0]  rdata;
    logic        rdata_valid;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  logic [11:0] ptr_val  [PTR_COUNT];
  logic        wr_high  [PTR_COUNT];
  logic        wr_low   [PTR_COUNT];
  step_t       step_ctl [PTR_COUNT];

  // Decode results, also watched by the checks below
  logic [11:0] eff_addr;
  decode_t     eff_dec;
  logic [11:0] sel_ptr;
  logic        indirect;
  logic [11:0] tgt_addr;
  decode_t     tgt_dec;
  logic        tgt_virtual;
  logic        tgt_reg;
  logic        own_write;
  step_t       step_req;

  for (genvar g = 0; g < PTR_COUNT; g++)
  begin : g_ptr
    pointer_pair #(
      .WIDTH (ADDR_W)
    ) u_pair (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .wr_high_in (wr_high[g]),
      .wr_low_in  (wr_low[g]),
      .wdata_in   (wdata_in),
      .step_in    (step_ctl[g]),
      .value_out  (ptr_val[g])
    );
  end

  always_comb
  begin
    next_s = s;
    next_s.mem_rd      = 1'b0;
    next_s.mem_wr      = 1'b0;
    next_s.int_rd      = 1'b0;
    next_s.rdata_valid = 1'b0;
    for (int n = 0; n < PTR_COUNT; n++)
    begin
      wr_high[n]  = 1'b0;
      wr_low[n]   = 1'b0;
      step_ctl[n] = STEP_HOLD;
    end

    // Direct address formation
    if (access_select_in)
      eff_addr = {bank_select_register_in, file_addr_in};
    else if (extended_instruction_enable_in && file_addr_in <= LIT_OFFSET_MAX)
      eff_addr = ptr_val[2] + {4'h0, file_addr_in};
    else if (file_addr_in > LIT_OFFSET_MAX)
      eff_addr = {ACCESS_HIGH_PAGE, file_addr_in};
    else
      eff_addr = {ACCESS_LOW_PAGE, file_addr_in};

    // An operand address redirects through its pointer; all 12 address bits, bank bits included, are decoded
    eff_dec  = decode_addr(eff_addr);
    sel_ptr  = ptr_val[eff_dec.idx];
    indirect = eff_dec.hit && eff_dec.kind != OP_HIGH && eff_dec.kind != OP_LOW;
    step_req = STEP_HOLD;
    tgt_addr = eff_addr;
    if (indirect)
    begin
      case (eff_dec.kind)
        OP_PLAIN:
          tgt_addr = sel_ptr;
        OP_POST_INCREMENT_OPERAND:
        begin
          tgt_addr = sel_ptr;
          step_req = STEP_INC;
        end
        OP_POST_DECREMENT_OPERAND:
        begin
          tgt_addr = sel_ptr;
          step_req = STEP_DEC;
        end
        OP_PRE_INCREMENT_OPERAND:
        begin
          tgt_addr = sel_ptr + PTR_STEP;
          step_req = STEP_INC;
        end
        OP_W_OFFSET_OPERAND:
          tgt_addr = sel_ptr + {{4{w_in[7]}}, w_in};
        default:
          tgt_addr = sel_ptr;
      endcase
    end

    tgt_dec     = decode_addr(tgt_addr);
    tgt_virtual = indirect && tgt_dec.hit
                  && tgt_dec.kind != OP_HIGH && tgt_dec.kind != OP_LOW;
    tgt_reg     = tgt_dec.hit && (tgt_dec.kind == OP_HIGH || tgt_dec.kind == OP_LOW);
    own_write   = indirect && tgt_reg && acc_write_in && tgt_dec.idx == eff_dec.idx;

    // No request means no data access at all; the core sends none for
    // inherent or literal instructions, so those run the same in either mode
    if (acc_valid_in)
    begin
      // Stepping drives only the pointer; no flag leaves this block
      if (indirect && !own_write)
        step_ctl[eff_dec.idx] = step_req;
      if (tgt_virtual)
      begin
        if (!acc_write_in)
        begin
          next_s.int_rd   = 1'b1;
          next_s.int_data = ZERO_BYTE;
        end
      end
      else if (tgt_reg)
      begin
        if (acc_write_in)
        begin
          wr_high[tgt_dec.idx] = tgt_dec.kind == OP_HIGH;
          wr_low[tgt_dec.idx]  = tgt_dec.kind == OP_LOW;
        end
        else
        begin
          next_s.int_rd = 1'b1;
          if (tgt_dec.kind == OP_HIGH)
            next_s.int_data = {HIGH_UNUSED_BITS, ptr_val[tgt_dec.idx][11:8]};
          else
            next_s.int_data = ptr_val[tgt_dec.idx][7:0];
        end
      end
      else
      begin
        next_s.mem_addr  = tgt_addr;
        next_s.mem_wdata = wdata_in;
        next_s.mem_wr    = acc_write_in;
        next_s.mem_rd    = !acc_write_in;
      end
    end

    // Read answer one cycle after the memory strobe
    if (s.mem_rd)
    begin
      next_s.rdata       = mem_rdata_in;
      next_s.rdata_valid = 1'b1;
    end
    else if (s.int_rd)
    begin
      next_s.rdata       = s.int_data;
      next_s.rdata_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign mem_addr_out     = s.mem_addr;
  assign mem_rd_out       = s.mem_rd;
  assign mem_wr_out       = s.mem_wr;
  assign mem_wdata_out    = s.mem_wdata;
  assign rdata_out        = s.rdata;
  assign rdata_valid_out  = s.rdata_valid;
  assign pointer_zero_out = ptr_val[0];
  assign pointer_one_out  = ptr_val[1];
  assign pointer_two_out  = ptr_val[2];

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic mem_req;
  assign mem_req = acc_valid_in && !tgt_virtual && !tgt_reg;

  chk_plain_stable: assert property (
    acc_valid_in && indirect && eff_dec.kind == OP_PLAIN && !tgt_reg
    |=> ptr_val[$past(eff_dec.idx)] == $past(sel_ptr))
    else $error("plain operand changed its pointer");
  chk_post_decrement_operand_step: assert property (
    mem_req && indirect && eff_dec.kind == OP_POST_DECREMENT_OPERAND
    |=> mem_addr_out == $past(sel_ptr)
        && ptr_val[$past(eff_dec.idx)] == 12'($past(sel_ptr) - PTR_STEP))
    else $error("post-decrement address or step wrong");
  chk_post_increment_operand_step: assert property (
    mem_req && indirect && eff_dec.kind == OP_POST_INCREMENT_OPERAND
    |=> mem_addr_out == $past(sel_ptr)
        && ptr_val[$past(eff_dec.idx)] == 12'($past(sel_ptr) + PTR_STEP))
    else $error("post-increment address or step wrong");
  chk_pre_increment_operand_step: assert property (
    mem_req && indirect && eff_dec.kind == OP_PRE_INCREMENT_OPERAND
    |=> mem_addr_out == 12'($past(sel_ptr) + PTR_STEP)
        && ptr_val[$past(eff_dec.idx)] == mem_addr_out)
    else $error("pre-increment address or step wrong");
  chk_w_offset_operand_offset: assert property (
    mem_req && indirect && eff_dec.kind == OP_W_OFFSET_OPERAND
    |=> mem_addr_out == 12'($past(sel_ptr) + {{4{$past(w_in[7])}}, $past(w_in)})
        && ptr_val[$past(eff_dec.idx)] == $past(sel_ptr))
    else $error("w offset address wrong or pointer moved");
  chk_virtual_zero: assert property (
    acc_valid_in && !acc_write_in && tgt_virtual
    |=> !mem_rd_out ##1 rdata_valid_out && rdata_out == ZERO_BYTE)
    else $error("virtual operand read did not return zero");
  chk_virtual_nop: assert property (
    acc_valid_in && acc_write_in && tgt_virtual
    |=> !mem_wr_out && ptr_val[$past(tgt_dec.idx)] == $past(ptr_val[tgt_dec.idx]))
    else $error("virtual operand write had an effect");
  chk_own_write: assert property (
    acc_valid_in && own_write && tgt_dec.kind == OP_LOW
    |=> ptr_val[$past(eff_dec.idx)][7:0] == $past(wdata_in))
    else $error("own pair write was stepped");
  chk_bank_direct: assert property (
    mem_req && access_select_in && !indirect
    |=> mem_addr_out == {$past(bank_select_register_in), $past(file_addr_in)})
    else $error("banked address wrong");
  chk_literal_offset: assert property (
    mem_req && !access_select_in && extended_instruction_enable_in
    && file_addr_in <= LIT_OFFSET_MAX && !indirect
    |=> mem_addr_out == 12'($past(ptr_val[2]) + {4'h0, $past(file_addr_in)}))
    else $error("literal offset address wrong");
  chk_access_page: assert property (
    mem_req && !access_select_in && !indirect
    && !(extended_instruction_enable_in && file_addr_in <= LIT_OFFSET_MAX)
    |=> mem_addr_out[7:0] == $past(file_addr_in)
        && mem_addr_out[11:8] == ($past(file_addr_in) > LIT_OFFSET_MAX
                                  ? ACCESS_HIGH_PAGE : ACCESS_LOW_PAGE))
    else $error("access bank address wrong");
  chk_high_read: assert property (
    acc_valid_in && !acc_write_in && tgt_reg && tgt_dec.kind == OP_HIGH
    |=> ##1 rdata_valid_out && rdata_out[7:4] == HIGH_UNUSED_BITS)
    else $error("pointer high byte read shows unused bits");
  chk_mem_answer: assert property (
    mem_rd_out |=> rdata_valid_out && rdata_out == $past(mem_rdata_in))
    else $error("memory read answer wrong");
  chk_internal_only: assert property (
    acc_valid_in && (tgt_virtual || tgt_reg) |=> !mem_rd_out && !mem_wr_out)
    else $error("operand or pointer access reached memory");

endmodule

// File: test/data_ram_model.sv
// Behavioural data RAM answering the block's memory port
`timescale 1ns/1ns
module data_ram_model
(
  // Clock
  input  wire logic        sys_clk_in,
  // Memory port
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [4096];
  logic [7:0] last;

  initial
  begin
    last = 8'h00;
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8);
  end

  // Outside a read the bus shows the inverse of its last value, so stale data cannot pass
  assign rdata_out = rd_in ? mem[addr_in] : ~last;

  always @(posedge sys_clk_in)
  begin
    if (rd_in)
      last <= mem[addr_in];
    if (wr_in)
      mem[addr_in] <= wdata_in;
  end
endmodule

// File: test/tb_indirect_data_address_unit.sv
// Self-checking bench for the indirect data address unit
`timescale 1ns/1ns
module tb_indirect_data_address_unit;
  import indirect_addr_pkg::*;

  logic        sys_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        ext = 1'b0;
  logic        vld = 1'b0;
  logic        wr = 1'b0;
  logic        asel = 1'b0;
  logic [7:0]  fa = 8'h00;
  logic [3:0]  bk = 4'h0;
  logic [7:0]  w = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [11:0] mem_addr_out;
  logic        mem_rd_out;
  logic        mem_wr_out;
  logic [7:0]  mem_wdata_out;
  logic [7:0]  mem_rdata_in;
  logic [7:0]  rdata_out;
  logic        rdata_valid_out;
  logic [11:0] p0;
  logic [11:0] p1;
  logic [11:0] p2;
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 92;
  logic [20:0] mq [$];
  logic [7:0]  rq [$];
  logic [7:0]  sh [4096];

  initial
  begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  indirect_data_address_unit DUT (
    .sys_clk_in                     (sys_clk_in),
    .nrst_in                        (nrst_in),
    .extended_instruction_enable_in (ext),
    .acc_valid_in                   (vld),
    .acc_write_in                   (wr),
    .access_select_in               (asel),
    .file_addr_in                   (fa),
    .bank_select_register_in        (bk),
    .w_in                           (w),
    .wdata_in                       (wd),
    .mem_addr_out                   (mem_addr_out),
    .mem_rd_out                     (mem_rd_out),
    .mem_wr_out                     (mem_wr_out),
    .mem_wdata_out                  (mem_wdata_out),
    .mem_rdata_in                   (mem_rdata_in),
    .rdata_out                      (rdata_out),
    .rdata_valid_out                (rdata_valid_out),
    .pointer_zero_out               (p0),
    .pointer_one_out                (p1),
    .pointer_two_out                (p2)
  );

  data_ram_model ram (
    .sys_clk_in (sys_clk_in),
    .rd_in      (mem_rd_out),
    .wr_in      (mem_wr_out),
    .addr_in    (mem_addr_out),
    .wdata_in   (mem_wdata_out),
    .rdata_out  (mem_rdata_in)
  );

  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One request per falling edge; m says a memory strobe must follow at address ea
  task automatic acc(input logic w_r, input logic a, input logic [3:0] b, input logic [7:0] f,
                     input logic [7:0] d, input logic m, input logic [11:0] ea,
                     input logic [7:0] er);
    vld = 1'b1;
    wr = w_r;
    asel = a;
    bk = b;
    fa = f;
    wd = d;
    if (m)
      mq.push_back({w_r, ea, w_r ? d : 8'h00});
    if (m && w_r)
      sh[ea] = d;
    if (!w_r)
      rq.push_back(m ? sh[ea] : er);
    @(negedge sys_clk_in);
  endtask

  task automatic idle(input int n);
    vld = 1'b0;
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Results are paired with the oldest expectation as they appear
  always @(negedge sys_clk_in)
  begin
    if (nrst_in && (mem_rd_out || mem_wr_out))
    begin
      if (mq.size() == 0)
        chk("mem_strobe", 13'h0, 13'h1fff);
      else
        chk("mem_access", mq.pop_front(),
            {mem_wr_out, mem_addr_out, mem_wr_out ? mem_wdata_out : 8'h00});
    end
    if (nrst_in && rdata_valid_out)
    begin
      if (rq.size() == 0)
        chk("rdata_valid", 13'h0, 13'h1fff);
      else
        chk("rdata", {5'h0, rq.pop_front()}, {5'h0, rdata_out});
    end
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    stop_test();
  end

  initial
  begin
    for (int i = 0; i < 4096; i++)
      sh[i] = 8'(i) ^ 8'(i >> 8);
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    nrst_in = 1'b1;
    idle(2);
    chk("reset_ptrs", 13'h0, {1'b0, p0 | p1 | p2});
    acc(1, 0, 4'h0, 8'hea, 8'hf1, 0, 0, 0);
    acc(1, 1, 4'hf, 8'he9, 8'hff, 0, 0, 0);
    acc(0, 0, 4'h0, 8'hea, 8'h00, 0, 0, 8'h01);
    acc(1, 1, 4'hf, 8'hee, 8'ha5, 1, 12'h1ff, 0);
    idle(2);
    chk("ptr0_carry", 13'h200, {1'b0, p0});
    acc(0, 1, 4'hf, 8'hed, 8'h00, 1, 12'h200, 0);
    acc(0, 1, 4'hf, 8'hee, 8'h00, 1, 12'h1ff, 0);
    acc(0, 1, 4'hf, 8'hec, 8'h00, 1, 12'h201, 0);
    ext = 1'($random(seed));
    acc(0, 1, 4'hf, 8'hef, 8'h00, 1, 12'h201, 0);
    for (int i = 0; i < 5; i++)
    begin
      w = (i == 0) ? 8'h80 : 8'($random(seed));
      acc(0, 1, 4'hf, 8'heb, 8'h00, 1, 12'h201 + {{4{w[7]}}, w}, 0);
    end
    idle(2);
    chk("ptr0_hold", 13'h201, {1'b0, p0});
    acc(1, 1, 4'hf, 8'hea, 8'h0f, 0, 0, 0);
    acc(1, 1, 4'hf, 8'he9, 8'he7, 0, 0, 0);
    acc(0, 1, 4'hf, 8'hef, 8'h00, 0, 0, 8'h00);
    acc(1, 1, 4'hf, 8'hef, 8'h3c, 0, 0, 0);
    acc(1, 1, 4'hf, 8'hda, 8'h0f, 0, 0, 0);
    acc(1, 1, 4'hf, 8'hd9, 8'hd9, 0, 0, 0);
    acc(1, 1, 4'hf, 8'hdd, 8'h34, 0, 0, 0);
    idle(2);
    chk("ptr0_op", 13'hfe7, {1'b0, p0});
    chk("ptr1_nop", 13'h000, {1'b0, p1});
    chk("ptr2_own", 13'hf34, {1'b0, p2});
    ext = 1'b1;
    acc(0, 0, 4'h0, 8'h5f, 8'h00, 1, 12'hf93, 0);
    acc(1, 0, 4'h0, 8'h00, 8'($random(seed)), 1, 12'hf34, 0);
    acc(0, 0, 4'h0, 8'h00, 8'h00, 1, 12'hf34, 0);
    acc(0, 0, 4'h0, 8'h60, 8'h00, 1, 12'hf60, 0);
    acc(0, 1, 4'h3, 8'h10, 8'h00, 1, 12'h310, 0);
    acc(1, 0, 4'h0, 8'hea, 8'h02, 0, 0, 0);
    acc(1, 0, 4'h0, 8'he9, 8'h00, 0, 0, 0);
    acc(0, 1, 4'hf, 8'hef, 8'h00, 1, 12'h200, 0);
    ext = 1'b0;
    acc(0, 0, 4'h0, 8'h10, 8'h00, 1, 12'h010, 0);
    acc(0, 0, 4'h0, 8'h5f, 8'h00, 1, 12'h05f, 0);
    idle(4);
    chk("pending", 13'h0, 13'(mq.size() + rq.size()));
    stop_test();
  end
endmodule
